// ==== core/led_dim_consts.vh ====
`ifndef LED_DIM_CONSTS_VH
`define LED_DIM_CONSTS_VH
`define STANDALONE_ADDR 7'h60
`define BUS_ADDR_BASE 7'h64
`define REG_CONFIG 8'h00
`define REG_PWM_DIM 8'h01
`define REG_CH1_DIM 8'h02
`define REG_STATUS 8'h03
`define CONFIG_CLKOUT_BIT 6
`define CONFIG_RESET 8'h00
`define PWM_DIM_RESET 8'h00
`define CH1_DIM_RESET 8'hff
`endif

// ==== core/led_dimming_mode_control.v ====
// Functional notes
// - Bus mode if either address select is high; standalone when both grounded.
// - Bus mode stays idle after reset until the PWM dimming register is written.
// - Standalone mode starts at the first PWM input rising edge after reset.
// - Standalone address is 1100000; PWM dimming registers are then inaccessible.
// - Current target scale equals code plus one over 256.
// - Channel 1 dimming code is bus accessible and resets to 255.
// - Each code bit adds a binary-weighted share, one 256th up to one half.
// - Clock output is off after reset; config bit 6 enables it.
`timescale 1ns/1ns
`default_nettype none
`include "led_dim_consts.vh"
module led_dimming_mode_control
(
	input wire clk_sys,
	input wire srst,
	input wire scl_in,
	input wire sda_in,
	output reg sda_out,
	output reg sda_oe,
	input wire address_select_a,
	input wire address_select_b,
	input wire pwm_dim_in,
	input wire osc_clk,
	input wire sync_clock_pin_in,
	output reg sync_clock_pin_out,
	output reg sync_clock_pin_oe,
	output reg sync_ref,
	output reg bus_mode,
	output reg running,
	output reg [7:0] ch1_analog_dim_code,
	output reg [8:0] current_scale
);
	localparam ST_IDLE = 4'h0;
	localparam ST_ADDR = 4'h1;
	localparam ST_ACK_ADDR = 4'h2;
	localparam ST_REG = 4'h3;
	localparam ST_ACK_REG = 4'h4;
	localparam ST_WDATA = 4'h5;
	localparam ST_ACK_DATA = 4'h6;
	localparam ST_RDATA = 4'h7;
	localparam ST_RACK = 4'h8;
	localparam [6:0] BUS_BASE = `BUS_ADDR_BASE;

	reg scl_s1, scl_s2, scl_d;
	reg sda_s1, sda_s2, sda_d;
	reg asa_s1, asa_s2, asb_s1, asb_s2;
	reg pwm_s1, pwm_s2, pwm_d;
	reg osc_s1, osc_s2;
	reg syn_s1;
	reg [3:0] state;
	reg [3:0] bitcnt;
	reg [7:0] shift;
	reg [7:0] pointer;
	reg rw;
	reg nack;
	reg [7:0] config_reg;
	reg [7:0] pwm_dim;
	wire scl_rise;
	wire scl_fall;
	wire start_cond;
	wire stop_cond;
	wire [6:0] my_addr;
	wire next_bus_mode;
	wire pwm_rise;
	wire pwm_ok;
	wire [7:0] rd_val;

	assign scl_rise = scl_s2 & ~scl_d;
	assign scl_fall = ~scl_s2 & scl_d;
	assign start_cond = scl_s2 & scl_d & sda_d & ~sda_s2;
	assign stop_cond = scl_s2 & scl_d & ~sda_d & sda_s2;
	assign next_bus_mode = asa_s2 | asb_s2;
	assign my_addr = next_bus_mode ? {BUS_BASE[6:2], asa_s2, asb_s2} : `STANDALONE_ADDR;
	assign pwm_ok = bus_mode;
	assign pwm_rise = pwm_s2 & ~pwm_d;

	function [7:0] read_reg;
		input [7:0] ptr;
		input [7:0] cfg;
		input [7:0] pwm;
		input [7:0] adim;
		input pok;
		input run;
		input bm;
		begin
			case (ptr)
				`REG_CONFIG: read_reg = cfg;
				`REG_PWM_DIM: read_reg = pok ? pwm : 8'h00;
				`REG_CH1_DIM: read_reg = adim;
				`REG_STATUS: read_reg = {6'h00, run, bm};
				default: read_reg = 8'h00;
			endcase
		end
	endfunction

	assign rd_val = read_reg(pointer, config_reg, pwm_dim, ch1_analog_dim_code, pwm_ok, running, bus_mode);

	always @(posedge clk_sys)
	begin
		if (srst)
		begin
			scl_s1 <= 1'b1;
			scl_s2 <= 1'b1;
			scl_d <= 1'b1;
			sda_s1 <= 1'b1;
			sda_s2 <= 1'b1;
			sda_d <= 1'b1;
			asa_s1 <= 1'b0;
			asa_s2 <= 1'b0;
			asb_s1 <= 1'b0;
			asb_s2 <= 1'b0;
			pwm_s1 <= 1'b1;
			pwm_s2 <= 1'b1;
			pwm_d <= 1'b1;
			osc_s1 <= 1'b0;
			osc_s2 <= 1'b0;
			syn_s1 <= 1'b0;
			sync_ref <= 1'b0;
		end
		else
		begin
			scl_s1 <= scl_in;
			scl_s2 <= scl_s1;
			scl_d <= scl_s2;
			sda_s1 <= sda_in;
			sda_s2 <= sda_s1;
			sda_d <= sda_s2;
			asa_s1 <= address_select_a;
			asa_s2 <= asa_s1;
			asb_s1 <= address_select_b;
			asb_s2 <= asb_s1;
			pwm_s1 <= pwm_dim_in;
			pwm_s2 <= pwm_s1;
			pwm_d <= pwm_s2;
			osc_s1 <= osc_clk;
			osc_s2 <= osc_s1;
			syn_s1 <= sync_clock_pin_in;
			sync_ref <= syn_s1;
		end
	end

	always @(posedge clk_sys)
	begin
		if (srst)
		begin
			bus_mode <= 1'b0;
			running <= 1'b0;
			sync_clock_pin_out <= 1'b0;
			sync_clock_pin_oe <= 1'b0;
			current_scale <= 9'h100;
		end
		else
		begin
			bus_mode <= next_bus_mode;
			if (next_bus_mode && state == ST_ACK_DATA && scl_fall && pointer == `REG_PWM_DIM)
				running <= 1'b1;
			else if (!next_bus_mode && pwm_rise)
				running <= 1'b1;
			sync_clock_pin_out <= osc_s2 & config_reg[`CONFIG_CLKOUT_BIT];
			sync_clock_pin_oe <= config_reg[`CONFIG_CLKOUT_BIT];
			current_scale <= {1'b0, ch1_analog_dim_code} + 9'h001;
		end
	end

	always @(posedge clk_sys)
	begin
		if (srst)
		begin
			state <= ST_IDLE;
			bitcnt <= 4'h0;
			shift <= 8'h00;
			pointer <= 8'h00;
			rw <= 1'b0;
			nack <= 1'b0;
			sda_out <= 1'b0;
			sda_oe <= 1'b0;
			config_reg <= `CONFIG_RESET;
			pwm_dim <= `PWM_DIM_RESET;
			ch1_analog_dim_code <= `CH1_DIM_RESET;
		end
		else if (stop_cond)
		begin
			state <= ST_IDLE;
			sda_oe <= 1'b0;
		end
		else if (start_cond)
		begin
			state <= ST_ADDR;
			bitcnt <= 4'h0;
			sda_oe <= 1'b0;
		end
		else
		begin
			case (state)
				ST_IDLE:
				begin
					sda_oe <= 1'b0;
				end
				ST_ADDR, ST_REG, ST_WDATA:
				begin
					if (scl_rise && bitcnt != 4'h8)
					begin
						shift <= {shift[6:0], sda_s2};
						bitcnt <= bitcnt + 4'h1;
					end
					else if (scl_fall && bitcnt == 4'h8)
					begin
						bitcnt <= 4'h0;
						if (state == ST_ADDR)
						begin
							if (shift[7:1] == my_addr)
							begin
								rw <= shift[0];
								sda_oe <= 1'b1;
								state <= ST_ACK_ADDR;
							end
							else
								state <= ST_IDLE;
						end
						else if (state == ST_REG)
						begin
							pointer <= shift;
							sda_oe <= 1'b1;
							state <= ST_ACK_REG;
						end
						else
						begin
							case (pointer)
								`REG_CONFIG: config_reg <= shift;
								`REG_PWM_DIM: if (pwm_ok) pwm_dim <= shift;
								`REG_CH1_DIM: ch1_analog_dim_code <= shift;
								default: ;
							endcase
							sda_oe <= 1'b1;
							state <= ST_ACK_DATA;
						end
					end
				end
				ST_ACK_ADDR, ST_ACK_REG, ST_ACK_DATA:
				begin
					if (scl_fall)
					begin
						if (state == ST_ACK_DATA)
							pointer <= pointer + 8'h01;
						if (state == ST_ACK_ADDR && rw)
						begin
							shift <= rd_val;
							sda_oe <= ~rd_val[7];
							bitcnt <= 4'h1;
							state <= ST_RDATA;
						end
						else
						begin
							sda_oe <= 1'b0;
							state <= (state == ST_ACK_ADDR) ? ST_REG : ST_WDATA;
						end
					end
				end
				ST_RDATA:
				begin
					if (scl_fall)
					begin
						if (bitcnt == 4'h8)
						begin
							sda_oe <= 1'b0;
							pointer <= pointer + 8'h01;
							state <= ST_RACK;
						end
						else
						begin
							sda_oe <= ~shift[6];
							shift <= {shift[6:0], 1'b0};
							bitcnt <= bitcnt + 4'h1;
						end
					end
				end
				ST_RACK:
				begin
					if (scl_rise)
						nack <= sda_s2;
					else if (scl_fall)
					begin
						if (nack)
							state <= ST_IDLE;
						else
						begin
							shift <= rd_val;
							sda_oe <= ~rd_val[7];
							bitcnt <= 4'h1;
							state <= ST_RDATA;
						end
					end
				end
				default:
				begin
					state <= ST_IDLE;
				end
			endcase
		end
	end
endmodule // led_dimming_mode_control
`default_nettype wire

// ==== dv/i2c_host.sv ====
`timescale 1ns/1ns
`default_nettype none
module i2c_host
(
	input wire logic clk_sys,
	input wire logic sda,
	output logic scl,
	output logic sda_low
);
	logic [7:0] rx;
	initial scl = 1'b1;
	initial sda_low = 1'b0;
	task automatic q(input logic c, input logic v);
		scl <= c;
		sda_low <= !v;
		repeat (2) @(posedge clk_sys);
	endtask
	task automatic st();
		q(0, 1);
		q(1, 1);
		q(1, 0);
		q(0, 0);
	endtask
	task automatic sp();
		q(0, 0);
		q(1, 0);
		q(1, 1);
	endtask
	task automatic xfer(input logic [7:0] tx, input logic mack, output logic ack);
		for (int i = 7; i >= 0; i--)
		begin
			q(0, tx[i]);
			q(1, tx[i]);
			rx[i] = sda;
			q(1, tx[i]);
			q(0, tx[i]);
		end
		q(0, mack);
		q(1, mack);
		ack = !sda;
		q(1, mack);
		q(0, mack);
	endtask
endmodule // i2c_host
`default_nettype wire

// ==== dv/led_dim_monitor.sv ====
`timescale 1ns/1ns
`default_nettype none
module led_dim_monitor
(
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic sda_oe,
	input wire logic address_select_a,
	input wire logic address_select_b,
	input wire logic pwm_dim_in,
	input wire logic sync_clock_pin_out,
	input wire logic sync_clock_pin_oe,
	input wire logic bus_mode,
	input wire logic running,
	input wire logic [7:0] ch1_analog_dim_code,
	input wire logic [8:0] current_scale
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);
	property p_bus; (address_select_a | address_select_b)[*8] |-> bus_mode; endproperty
	a_bus: assert property (p_bus) else $error("mode");
	property p_sa; !(address_select_a | address_select_b)[*8] |-> !bus_mode; endproperty
	a_sa: assert property (p_sa) else $error("mode");
	property p_idle; bus_mode && $rose(running) |-> $past(sda_oe) || $past(sda_oe, 2); endproperty
	a_idle: assert property (p_idle) else $error("idle");
	property p_start; !bus_mode && $rose(pwm_dim_in) |-> ##[1:5] running; endproperty
	a_start: assert property (p_start) else $error("start");
	property p_scale; 1 |=> current_scale == $past(ch1_analog_dim_code) + 9'h1; endproperty
	a_scale: assert property (p_scale) else $error("scale");
	property p_dimrst; $fell(srst) |-> ch1_analog_dim_code == 8'hff; endproperty
	a_dimrst: assert property (p_dimrst) else $error("code");
	property p_wr; $changed(ch1_analog_dim_code) |-> ##[0:1] sda_oe; endproperty
	a_wr: assert property (p_wr) else $error("write");
	property p_clkoff; !sync_clock_pin_oe[*2] |-> !sync_clock_pin_out; endproperty
	a_clkoff: assert property (p_clkoff) else $error("clkout");
	property p_clkon; sync_clock_pin_oe[*4] |-> $changed(sync_clock_pin_out); endproperty
	a_clkon: assert property (p_clkon) else $error("clkout stuck");
	c_bus: cover property (bus_mode && running);
	c_sa: cover property (!bus_mode && running);
	c_clk: cover property (sync_clock_pin_oe);
endmodule // led_dim_monitor
`default_nettype wire

// ==== dv/led_dimming_mode_control_bench.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "led_dim_consts.vh"
module led_dimming_mode_control_bench;
	logic clk_sys = 1'b0;
	logic srst = 1'b1;
	logic adr_a = 1'b0;
	logic pwm = 1'b0;
	logic osc = 1'b0;
	logic sync_in = 1'b0;
	logic k;
	logic [7:0] d;
	int fails = 0;
	int checked = 0;
	wire logic scl, sda_low, sda_oe, oe, run, bm;
	wire logic sda = !(sda_low | sda_oe);
	wire logic [7:0] code;
	wire logic [8:0] scale;
	initial forever #50 clk_sys = !clk_sys;
	always @(posedge clk_sys) osc <= !osc;
	initial forever #90 sync_in = !sync_in;
	i2c_host i2c_host_i (.clk_sys(clk_sys), .sda(sda), .scl(scl), .sda_low(sda_low));
	led_dimming_mode_control led_dimming_mode_control_i (.clk_sys(clk_sys), .srst(srst), .scl_in(scl),
		.sda_in(sda), .sda_out(), .sda_oe(sda_oe), .address_select_a(adr_a), .address_select_b(1'b0),
		.pwm_dim_in(pwm), .osc_clk(osc), .sync_clock_pin_in(sync_in), .sync_clock_pin_out(),
		.sync_clock_pin_oe(oe), .sync_ref(), .bus_mode(bm), .running(run), .ch1_analog_dim_code(code),
		.current_scale(scale));
	task automatic chk(input string n, input logic [8:0] s, input logic [8:0] e);
		@(negedge clk_sys);
		checked++;
		if (s !== e)
		begin
			fails++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
		@(posedge clk_sys);
	endtask
	task automatic rst();
		srst <= 1'b1;
		repeat (5) @(posedge clk_sys);
		srst <= 1'b0;
		repeat (8) @(posedge clk_sys);
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] r, input logic [7:0] v);
		logic k1;
		logic k2;
		i2c_host_i.st();
		i2c_host_i.xfer({a, 1'b0}, 1'b1, k);
		i2c_host_i.xfer(r, 1'b1, k1);
		i2c_host_i.xfer(v, 1'b1, k2);
		i2c_host_i.sp();
		k = k & k1 & k2;
	endtask
	task automatic rd(input logic [6:0] a, input logic [7:0] r);
		i2c_host_i.st();
		i2c_host_i.xfer({a, 1'b0}, 1'b1, k);
		i2c_host_i.xfer(r, 1'b1, k);
		i2c_host_i.st();
		i2c_host_i.xfer({a, 1'b1}, 1'b1, k);
		i2c_host_i.xfer(8'hff, 1'b1, k);
		i2c_host_i.sp();
		d = i2c_host_i.rx;
	endtask
	task automatic t_alone();
		chk("mode", bm, 9'h0);
		chk("code", code, 9'h0ff);
		chk("scale", scale, 9'h100);
		wr(`STANDALONE_ADDR, `REG_CH1_DIM, 8'h80);
		chk("ack", k, 9'h1);
		chk("scale", scale, 9'h081);
		rd(`STANDALONE_ADDR, `REG_CH1_DIM);
		chk("read", d, 9'h080);
		wr(7'h61, `REG_CH1_DIM, 8'h00);
		chk("nack", k, 9'h0);
		wr(`STANDALONE_ADDR, `REG_PWM_DIM, 8'h55);
		chk("idle", run, 9'h0);
		pwm <= 1'b1;
		repeat (5) @(posedge clk_sys);
		chk("run", run, 9'h1);
		$display("standalone test ended");
	endtask
	task automatic t_bus();
		adr_a <= 1'b1;
		pwm <= 1'b0;
		rst();
		chk("mode", bm, 9'h1);
		chk("clk_oe", oe, 9'h0);
		pwm <= 1'b1;
		repeat (5) @(posedge clk_sys);
		chk("idle", run, 9'h0);
		wr(7'h66, `REG_CONFIG, 8'h40);
		chk("clk_oe", oe, 9'h1);
		wr(7'h66, `REG_CH1_DIM, 8'h00);
		chk("scale", scale, 9'h001);
		wr(7'h66, `REG_PWM_DIM, 8'h7f);
		chk("run", run, 9'h1);
		$display("bus test ended");
	endtask
	task automatic stop_test();
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial
	begin
		rst();
		t_alone();
		t_bus();
		stop_test();
	end
	initial
	begin
		repeat (20000) @(posedge clk_sys);
		fails++;
		stop_test();
	end
endmodule // led_dimming_mode_control_bench
bind led_dimming_mode_control led_dim_monitor led_dim_monitor_i (.*);
`default_nettype wire
